/* rtl/bwhp_pkg.sv */
// Shared constants, enumerations and carriers of the byte-wide host port
package bwhp_pkg;

	// Clock and half period of the CPU output clock (sys_clk drives it)
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned H_NS          = 50;

	// Longest delays, in ns, from strobe high to ready high
	localparam int unsigned RDY_IDLE_NS   = 10 * H_NS + 10;
	localparam int unsigned RDY_DMA16_NS  = 18 * H_NS + 10;
	localparam int unsigned RDY_DMA32_NS  = 26 * H_NS + 10;
	localparam int unsigned RDY_CTRL_NS   = 6 * H_NS + 10;

	// Longest times round down to whole cycles
	localparam int unsigned RDY_IDLE_CYC  = (RDY_IDLE_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned RDY_DMA16_CYC = (RDY_DMA16_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned RDY_DMA32_CYC = (RDY_DMA32_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned RDY_CTRL_CYC  = (RDY_CTRL_NS * (CLK_HZ / 1_000_000)) / 1000;

	// Busy counter width and control register layout
	localparam int unsigned CNT_W         = 4;
	localparam int unsigned CORE_IRQ_BIT  = 2;
	localparam int unsigned HOST_IRQ_BIT  = 3;
	localparam logic        HOST_INTERRUPT_OUT_RST      = 1'b1;
	localparam logic [15:0] ADDR_RST      = 16'h0000;

	// Access kind chosen by the two type-select pins
	typedef enum logic [1:0] {ACC_CTRL, ACC_DATA_INC, ACC_ADDR, ACC_DATA} bwhp_acc_t;

	// Activity of the DMA controller sharing the internal bus
	typedef enum logic [1:0] {DMA_IDLE, DMA_16, DMA_32, DMA_RSVD} bwhp_dma_t;

	// Busy state of the port
	typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_CTRL} bwhp_st_t;

	// Host pins as seen by the device
	typedef struct packed {
		logic       host_chip_select_n;
		logic       host_strobe_a_n;
		logic       host_strobe_b_n;
		logic       byte_half_select;
		bwhp_acc_t  access_type_select;
		logic       host_read_write_select;
		logic [7:0] host_data_bus;
	} bwhp_pins_t;

	// Internal memory request
	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bwhp_mem_t;

endpackage

/* rtl/bwhp_port.sv */
// Byte-wide host port: host pins to internal memory, control register, interrupts
`timescale 1ns/1ps
`default_nettype none
module bwhp_port
	import bwhp_pkg::*;
(
	input  wire logic        sys_clk_i,          // CPU output clock
	input  wire logic        resetn_i,           // Async reset, active low
	input  wire bwhp_pins_t  pins_i,             // Host pins, asynchronous
	input  wire bwhp_dma_t   dma_mode_i,         // DMA activity on the shared bus
	input  wire logic        host_irq_req_i,     // Core asks to interrupt the host
	input  wire logic [15:0] mem_rdata_i,        // Memory read data
	input  wire logic        gpio_mode_i,        // Data pins used as GPIO
	input  wire logic [7:0]  gpio_out_i,         // GPIO output values
	input  wire logic [7:0]  gpio_dir_i,         // GPIO drive enables
	output logic      [7:0]  host_data_bus_o,    // Data pins, out value
	output logic      [7:0]  host_data_bus_oe_o, // Data pins, drive enables
	output logic             host_ready_out_o,   // Ready to host
	output logic             host_interrupt_out_o, // Host interrupt, active low
	output logic             core_irq_o,         // Pulse to the core
	output bwhp_mem_t        mem_o,              // Memory request
	output logic      [7:0]  gpio_in_o           // GPIO input values
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and strobe merge
	bwhp_pins_t s1_q, s2_q;
	logic       ds_q, ds_n, ds_fall, ds_rise;
	// merged strobe
	// Any one input high ends the transfer strobe
	assign ds_n    = s2_q.host_chip_select_n | s2_q.host_strobe_a_n | s2_q.host_strobe_b_n;
	assign ds_fall = ds_q & ~ds_n;
	assign ds_rise = ~ds_q & ds_n;
	// Two flops before any logic looks at the pins; idle pins read high
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_q <= '1;
			s2_q <= '1;
			ds_q <= 1'b1;
		end else begin
			s1_q <= pins_i;
			s2_q <= s1_q;
			ds_q <= ds_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Access capture, registers and data path
	logic        half_q, half_d, rnw_q, rnw_d, drive_q, drive_d, hold_q, hold_d;
	bwhp_acc_t   acc_q, acc_d;
	logic [7:0]  wbyte_q, wbyte_d, dout_q, dout_d, ctrl_q, ctrl_d;
	logic [15:0] addr_q, addr_d, rword_q, rword_d, wword_q, wword_d;
	logic        host_interrupt_out_q, host_interrupt_out_d, core_q, core_d;
	logic        start_mem, start_we, start_ctrl, irq_bits, mem_done;
	bwhp_st_t    st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, lat_c;
	bwhp_mem_t   mem_q, mem_d;
	// busy latency by DMA load, less the registered ready stage
	assign lat_c = (dma_mode_i == DMA_16) ? CNT_W'(RDY_DMA16_CYC - 1) :
		(dma_mode_i == DMA_32) ? CNT_W'(RDY_DMA32_CYC - 1) :
		CNT_W'(RDY_IDLE_CYC - 1);
	assign irq_bits = wbyte_q[CORE_IRQ_BIT] | wbyte_q[HOST_IRQ_BIT];
	assign mem_done = (st_q == ST_MEM) && (cnt_q == CNT_W'(1));
	// Decide, at strobe end, which transfer the access starts
	always_comb begin
		start_mem  = 1'b0;
		start_we   = 1'b0;
		start_ctrl = 1'b0;
		if (ds_rise && (st_q == ST_IDLE) && !gpio_mode_i) begin
			if (!rnw_q && half_q && (acc_q == ACC_DATA || acc_q == ACC_DATA_INC)) begin
				start_mem = 1'b1;
				start_we  = 1'b1;
			end else if (!rnw_q && half_q && acc_q == ACC_ADDR) begin
				start_mem = 1'b1;
			end else if (rnw_q && half_q && acc_q == ACC_DATA_INC) begin
				start_mem = 1'b1;
			end
			if (!rnw_q && acc_q == ACC_CTRL && irq_bits)
				start_ctrl = 1'b1;
		end
	end
	// Next values of the access, register and data path state
	always_comb begin
		half_d  = half_q;
		acc_d   = acc_q;
		rnw_d   = rnw_q;
		wbyte_d = wbyte_q;
		addr_d  = addr_q;
		wword_d = wword_q;
		rword_d = rword_q;
		ctrl_d  = ctrl_q;
		host_interrupt_out_d  = host_interrupt_out_q;
		core_d  = 1'b0;
		drive_d = drive_q;
		hold_d  = 1'b0;
		dout_d  = dout_q;
		if (ds_fall) begin
			half_d = s2_q.byte_half_select;
			acc_d  = s2_q.access_type_select;
			rnw_d  = s2_q.host_read_write_select;
		end
		// last byte seen while strobe low
		if (!ds_n)
			wbyte_d = s2_q.host_data_bus;
		// data bytes come from the prefetched word, high half first; control and address reads come from their registers
		if (ds_fall && s2_q.host_read_write_select && !gpio_mode_i) begin
			drive_d = 1'b1;
			if (s2_q.access_type_select == ACC_CTRL)
				dout_d = ctrl_q;
			else if (s2_q.access_type_select == ACC_ADDR)
				dout_d = s2_q.byte_half_select ? addr_q[7:0] : addr_q[15:8];
			else
				dout_d = s2_q.byte_half_select ? rword_q[7:0] : rword_q[15:8];
		end
		// hold one cycle after rise, then release
		if (ds_rise && drive_q)
			hold_d = 1'b1;
		if (hold_q && ds_n)
			drive_d = 1'b0;
		if (ds_rise && !rnw_q && !gpio_mode_i && st_q == ST_IDLE) begin
			if (acc_q == ACC_ADDR && !half_q)
				addr_d[15:8] = wbyte_q;
			else if (acc_q == ACC_ADDR)
				addr_d[7:0] = wbyte_q;
			else if (acc_q != ACC_CTRL && !half_q)
				wword_d[15:8] = wbyte_q;
			else if (acc_q != ACC_CTRL)
				wword_d[7:0] = wbyte_q;
			else begin
				// plain bits stored without a ready drop
				ctrl_d = wbyte_q & ~(8'h01 << CORE_IRQ_BIT) & ~(8'h01 << HOST_IRQ_BIT);
				core_d = wbyte_q[CORE_IRQ_BIT];
				if (wbyte_q[HOST_IRQ_BIT])
					host_interrupt_out_d = 1'b1;
			end
		end
		// core request sets the host interrupt; set wins over clear
		if (host_irq_req_i)
			host_interrupt_out_d = 1'b0;
		if (mem_done && !mem_q.we)
			rword_d = mem_rdata_i;
		else if (mem_done)
			rword_d = mem_q.wdata;
		if (mem_done && acc_q == ACC_DATA_INC)
			addr_d = addr_q + 16'h0001;
	end
	// Registers of the access and data path
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			half_q  <= 1'b0;
			acc_q   <= ACC_CTRL;
			rnw_q   <= 1'b0;
			wbyte_q <= 8'h00;
			addr_q  <= ADDR_RST;
			wword_q <= 16'h0000;
			rword_q <= 16'h0000;
			ctrl_q  <= 8'h00;
			host_interrupt_out_q  <= HOST_INTERRUPT_OUT_RST;
			core_q  <= 1'b0;
			drive_q <= 1'b0;
			hold_q  <= 1'b0;
			dout_q  <= 8'h00;
		end else begin
			half_q  <= half_d;
			acc_q   <= acc_d;
			rnw_q   <= rnw_d;
			wbyte_q <= wbyte_d;
			addr_q  <= addr_d;
			wword_q <= wword_d;
			rword_q <= rword_d;
			ctrl_q  <= ctrl_d;
			host_interrupt_out_q  <= host_interrupt_out_d;
			core_q  <= core_d;
			drive_q <= drive_d;
			hold_q  <= hold_d;
			dout_q  <= dout_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Busy sequencer, memory request and ready
	logic       rdy_q, rdy_d;
	logic [7:0] pin_o_q, pin_o_d, pin_oe_q, pin_oe_d, gin_q;
	logic [4:0] run_q; // Cycles spent busy, for the ready bound
	// A transfer started while busy is dropped; host must wait for ready
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		mem_d = mem_q;
		mem_d.req = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (start_mem) begin
					st_d      = ST_MEM;
					cnt_d     = lat_c;
					mem_d.req = 1'b1;
					mem_d.we  = start_we;
					mem_d.addr  = start_we ? addr_q :
						(acc_q == ACC_DATA_INC) ? addr_q + 16'h0001 : addr_d;
					mem_d.wdata = {wword_q[15:8], wbyte_q};
				end else if (start_ctrl) begin
					st_d  = ST_CTRL;
					cnt_d = CNT_W'(RDY_CTRL_CYC - 1);
				end
			end
			default: begin
				cnt_d = cnt_q - CNT_W'(1);
				if (cnt_q == CNT_W'(1))
					st_d = ST_IDLE;
			end
		endcase
		// chip select high forces ready high
		rdy_d = s2_q.host_chip_select_n | (st_d == ST_IDLE);
		// pins to GPIO when gpio_mode_i is set; read data leaves with its enable, never stale
		pin_o_d  = gpio_mode_i ? gpio_out_i : dout_d;
		pin_oe_d = gpio_mode_i ? gpio_dir_i : {8{drive_d}};
	end
	// ready and pins leave flip-flops on the clock edge
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q     <= ST_IDLE;
			cnt_q    <= '0;
			mem_q    <= '0;
			rdy_q    <= 1'b1;
			pin_o_q  <= 8'h00;
			pin_oe_q <= 8'h00;
			gin_q    <= 8'h00;
			run_q    <= 5'h00;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			mem_q    <= mem_d;
			rdy_q    <= rdy_d;
			pin_o_q  <= pin_o_d;
			pin_oe_q <= pin_oe_d;
			gin_q    <= s2_q.host_data_bus;
			run_q    <= (st_q == ST_IDLE) ? 5'h00 : run_q + 5'h01;
		end
	end
	assign host_data_bus_o      = pin_o_q;
	assign host_data_bus_oe_o   = pin_oe_q;
	assign host_ready_out_o     = rdy_q;
	assign host_interrupt_out_o = host_interrupt_out_q;
	assign core_irq_o           = core_q;
	assign mem_o                = mem_q;
	assign gpio_in_o            = gin_q;

	////////////////////////////////////////////////////////////////////////////
	// Assertions and covers
	property p_merge;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		ds_fall |-> !s2_q.host_chip_select_n && !s2_q.host_strobe_a_n && !s2_q.host_strobe_b_n;
	endproperty
	a_merge: assert property (p_merge) else $error("strobe fell with an input high");
	property p_half;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		ds_fall |=> half_q == $past(s2_q.byte_half_select);
	endproperty
	a_half: assert property (p_half) else $error("byte half not captured");
	property p_wbyte;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		ds_rise && !rnw_q && acc_q == ACC_ADDR && half_q && st_q == ST_IDLE && !gpio_mode_i
		|=> addr_q[7:0] == $past(wbyte_q);
	endproperty
	a_wbyte: assert property (p_wbyte) else $error("write byte lost at rise");
	property p_hold;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		ds_rise && drive_q && !gpio_mode_i ##1 ds_n |=> !pin_oe_q[0] [*2];
	endproperty
	a_hold: assert property (p_hold) else $error("read data not released");
	property p_second;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		ds_fall && s2_q.host_read_write_select && !gpio_mode_i |=> ##1 pin_oe_q == 8'hff;
	endproperty
	a_second: assert property (p_second) else $error("read byte not driven");
	property p_busy;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		start_mem ##1 !s2_q.host_chip_select_n |-> !host_ready_out_o;
	endproperty
	a_busy: assert property (p_busy) else $error("ready high during transfer");
	property p_bound;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		st_q != ST_IDLE |-> run_q < 5'(RDY_DMA32_CYC - 1);
	endproperty
	a_bound: assert property (p_bound) else $error("transfer too long");
	property p_cs;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		s2_q.host_chip_select_n |=> host_ready_out_o;
	endproperty
	a_cs: assert property (p_cs) else $error("ready low with chip select high");
	property p_ctrl;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		start_ctrl |=> st_q == ST_CTRL ##2 st_q == ST_IDLE;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("interrupt write busy length wrong");
	property p_plain;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		ds_rise && st_q == ST_IDLE && !rnw_q && acc_q == ACC_CTRL && !irq_bits |=> st_q == ST_IDLE;
	endproperty
	a_plain: assert property (p_plain) else $error("plain control write went busy");
	property p_host_interrupt_out;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		$fell(host_interrupt_out_o) |-> $past(host_irq_req_i);
	endproperty
	a_host_interrupt_out: assert property (p_host_interrupt_out) else $error("host interrupt without request");
	property p_core;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		core_irq_o |-> $past(ds_rise) && $past(acc_q == ACC_CTRL) && !$past(rnw_q);
	endproperty
	a_core: assert property (p_core) else $error("core interrupt without write");
	c_write:  cover property (@(posedge sys_clk_i) start_mem && start_we);
	c_read:   cover property (@(posedge sys_clk_i) start_mem && rnw_q);
	c_ctrl:   cover property (@(posedge sys_clk_i) start_ctrl);
	c_dma32:  cover property (@(posedge sys_clk_i) start_mem && dma_mode_i == DMA_32);
endmodule
`default_nettype wire

/* dv/bwhp_host.sv */
// Host processor model driving the byte-wide host port pins
`timescale 1ns/1ps
`default_nettype none
module bwhp_host
	import bwhp_pkg::*;
(
	input  wire logic       clk_i,  // CPU output clock
	input  wire logic       rdy_i,  // Ready from the port
	input  wire logic [7:0] dout_i, // Port data out
	input  wire logic [7:0] oe_i,   // Port drive enables
	output bwhp_pins_t      pins_o  // Host pins
);
	bwhp_pins_t p_q;
	logic       drv_q;
	logic [7:0] idle_q;

	initial begin
		p_q = '1;
		drv_q = 1'b0;
		idle_q = 8'h00;
	end

	// Undriven bus bits change every cycle so a stale value never reads as data
	always @(posedge clk_i) begin
		idle_q <= ~idle_q;
	end
	assign pins_o = {p_q[14:8], (drv_q ? p_q.host_data_bus : (oe_i & dout_i) | (~oe_i & idle_q))};

	////////////////////////////////////////////////////////////////////////////////
	// Drive or release the data pins outside a transfer
	task automatic drive(input logic on, input logic [7:0] v);
		@(posedge clk_i);
		drv_q <= on;
		p_q.host_data_bus <= v;
	endtask

	// One byte transfer; waits for ready under a bound of 40 cycles
	task automatic xfer(input logic rnw, input bwhp_acc_t acc, input logic half,
		input logic [7:0] wd, input logic cs_off, output logic [7:0] rd,
		output logic [7:0] roe, output int lat, output logic low);
		@(posedge clk_i);
		// no latch strobe pin, address driven on the same edge as the strobe
		p_q.host_chip_select_n <= 1'b0;
		p_q.host_strobe_a_n <= 1'b0;
		p_q.host_strobe_b_n <= 1'b0;
		// half and data held across both edges
		p_q.byte_half_select <= half;
		p_q.access_type_select <= acc;
		p_q.host_read_write_select <= rnw;
		p_q.host_data_bus <= wd;
		drv_q <= !rnw;
		repeat (4) @(posedge clk_i);
		rd = dout_i;
		roe = oe_i;
		p_q.host_strobe_a_n <= 1'b1;
		p_q.host_strobe_b_n <= 1'b1;
		if (cs_off) begin
			p_q.host_chip_select_n <= 1'b1;
		end
		lat = 0;
		low = 1'b0;
		// Ready may only fall a few edges after the rise, so look at least four
		while (!(rdy_i === 1'b1 && lat >= 4) && lat < 40) begin
			@(posedge clk_i);
			lat++;
			if (rdy_i !== 1'b1) begin
				low = 1'b1;
			end
		end
		@(posedge clk_i);
		p_q.host_chip_select_n <= 1'b1;
		drv_q <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* dv/test_bwhp_port.sv */
// Self-checking bench of the byte-wide host port
`timescale 1ns/1ps
`default_nettype none
module test_bwhp_port;
	import bwhp_pkg::*;
	logic       sys_clk_i = 1'b0;
	logic       resetn_i = 1'b0;
	bwhp_pins_t pins;
	bwhp_dma_t  dma_mode = DMA_IDLE;
	logic       host_irq_req = 1'b0;
	logic [15:0] mem_rdata;
	logic       gpio_mode = 1'b0;
	logic [7:0] gpio_out = 8'h00;
	logic [7:0] gpio_dir = 8'h00;
	logic [7:0] hd_o;
	logic [7:0] hd_oe;
	logic       rdy;
	logic       host_interrupt_out;
	logic       core_irq;
	bwhp_mem_t  mem_o;
	logic [7:0] gpio_in;
	logic [15:0] mem [16];
	bwhp_mem_t  last_q;
	int         n_req = 0;
	int         n_core = 0;
	int         n_mismatch = 0;
	int         comparisons = 0;
	logic [7:0] rd_g;
	logic [7:0] oe_g;
	int         lat_g;
	logic       low_g;

	always #50 sys_clk_i = ~sys_clk_i;

	bwhp_port u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .pins_i(pins),
		.dma_mode_i(dma_mode), .host_irq_req_i(host_irq_req), .mem_rdata_i(mem_rdata),
		.gpio_mode_i(gpio_mode), .gpio_out_i(gpio_out), .gpio_dir_i(gpio_dir),
		.host_data_bus_o(hd_o), .host_data_bus_oe_o(hd_oe), .host_ready_out_o(rdy),
		.host_interrupt_out_o(host_interrupt_out), .core_irq_o(core_irq), .mem_o(mem_o),
		.gpio_in_o(gpio_in));

	bwhp_host u_host (.clk_i(sys_clk_i), .rdy_i(rdy), .dout_i(hd_o), .oe_i(hd_oe),
		.pins_o(pins));

	// Memory with zero-latency read; the address stands until the next request
	assign mem_rdata = mem[mem_o.addr[3:0]];
	always @(posedge sys_clk_i) begin
		if (mem_o.req === 1'b1) begin
			n_req++;
			last_q <= mem_o;
			if (mem_o.we) begin
				mem[mem_o.addr[3:0]] <= mem_o.wdata;
			end
		end
		if (core_irq === 1'b1) begin
			n_core++;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One transfer; ready must be back within the latency plus the pin delays
	task automatic op(input logic rnw, input bwhp_acc_t acc, input logic half,
		input logic [7:0] wd, input int lat, input logic cs_off);
		u_host.xfer(rnw, acc, half, wd, cs_off, rd_g, oe_g, lat_g, low_g);
		if (lat_g >= 40) begin
			n_mismatch++;
			test_done();
		end
		// The host watches ready for four edges at least, so a access without wait reads 4
		check(16'(lat_g <= ((lat > 1) ? lat + 3 : 4)), 16'h0001);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check(16'(rdy), 16'h0001);
		check(16'(host_interrupt_out), 16'h0001);
		check(16'(hd_oe), 16'h0000);
		check(16'(mem_o.req), 16'h0000);
	endtask

	// Word writes under each DMA load, then read back
	task automatic t_mem;
		int lx [3] = '{5, 9, 13};
		for (int i = 0; i < 3; i++) begin
			dma_mode <= bwhp_dma_t'(i);
			op(1'b0, ACC_ADDR, 1'b0, 8'h00, lx[i], 1'b0);
			op(1'b0, ACC_ADDR, 1'b1, 8'(2 * i), lx[i], 1'b0);
			op(1'b0, ACC_DATA_INC, 1'b0, 8'ha0 + 8'(i), lx[i], 1'b0);
			op(1'b0, ACC_DATA_INC, 1'b1, 8'h5c + 8'(i), lx[i], 1'b0);
			check(16'(low_g), 16'h0001);
			check({last_q.we, last_q.addr[14:0]}, 16'h8000 | 16'(2 * i));
			check(last_q.wdata, {8'ha0 + 8'(i), 8'h5c + 8'(i)});
			op(1'b0, ACC_DATA_INC, 1'b0, 8'h33, lx[i], 1'b0);
			op(1'b0, ACC_DATA_INC, 1'b1, 8'hc4, lx[i], 1'b0);
			check(last_q.addr, 16'(2 * i + 1));
			op(1'b0, ACC_ADDR, 1'b1, 8'(2 * i), lx[i], 1'b0);
			op(1'b1, ACC_DATA, 1'b0, 8'h00, lx[i], 1'b0);
			check({rd_g, oe_g}, {8'ha0 + 8'(i), 8'hff});
			op(1'b1, ACC_DATA, 1'b1, 8'h00, 0, 1'b0);
			check({rd_g, 7'h00, low_g}, {8'h5c + 8'(i), 8'h00});
			check(16'(hd_oe), 16'h0000);
		end
		dma_mode <= DMA_IDLE;
	endtask

	// Control register: interrupt bits drop ready, other bits do not
	task automatic t_ctrl;
		int c0;
		c0 = n_core;
		op(1'b0, ACC_CTRL, 1'b1, 8'h04, 3, 1'b0);
		check({15'(n_core - c0), low_g}, 16'h0003);
		op(1'b0, ACC_CTRL, 1'b1, 8'h01, 0, 1'b0);
		check({15'(n_core - c0), low_g}, 16'h0002);
		op(1'b1, ACC_CTRL, 1'b1, 8'h00, 0, 1'b0);
		check(16'(rd_g), 16'h0001);
		@(posedge sys_clk_i);
		host_irq_req <= 1'b1;
		@(posedge sys_clk_i);
		host_irq_req <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		check(16'(host_interrupt_out), 16'h0000);
		op(1'b0, ACC_CTRL, 1'b1, 8'h08, 3, 1'b0);
		check({15'(host_interrupt_out), low_g}, 16'h0003);
	endtask

	// Chip select rising with the strobes keeps ready high through the write
	task automatic t_cs;
		op(1'b0, ACC_DATA, 1'b0, 8'h12, 5, 1'b0);
		op(1'b0, ACC_DATA, 1'b1, 8'h34, 0, 1'b1);
		check(16'(lat_g), 16'h0004);
		repeat (20) @(posedge sys_clk_i);
	endtask

	// Increment reads walk through memory; the address reads back advanced
	task automatic t_inc;
		op(1'b0, ACC_ADDR, 1'b0, 8'h00, 0, 1'b0);
		op(1'b0, ACC_ADDR, 1'b1, 8'h00, 5, 1'b0);
		op(1'b1, ACC_DATA_INC, 1'b0, 8'h00, 0, 1'b0);
		check(16'(rd_g), 16'h00a0);
		op(1'b1, ACC_DATA_INC, 1'b1, 8'h00, 5, 1'b0);
		check({rd_g, 7'h00, low_g}, 16'h5c01);
		op(1'b1, ACC_ADDR, 1'b1, 8'h00, 0, 1'b0);
		check(16'(rd_g), 16'h0001);
		op(1'b1, ACC_DATA, 1'b0, 8'h00, 0, 1'b0);
		check(16'(rd_g), 16'h0033);
	endtask

	// Data pins as general purpose IO; host strobes are ignored
	task automatic t_gpio;
		int r0;
		r0 = n_req;
		gpio_mode <= 1'b1;
		gpio_dir <= 8'hff;
		gpio_out <= 8'h5a;
		repeat (4) @(posedge sys_clk_i);
		check({hd_oe, hd_o}, 16'hff5a);
		gpio_dir <= 8'h00;
		u_host.drive(1'b1, 8'ha5);
		repeat (4) @(posedge sys_clk_i);
		check(16'(gpio_in), 16'h00a5);
		op(1'b0, ACC_ADDR, 1'b1, 8'h07, 0, 1'b0);
		check(16'(n_req - r0), 16'h0000);
		gpio_mode <= 1'b0;
	endtask

	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'h1111 * 16'(i);
		end
		repeat (12) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		t_reset();
		repeat (3) @(posedge sys_clk_i);
		t_mem();
		t_ctrl();
		t_cs();
		t_inc();
		t_gpio();
		test_done();
	end
endmodule
`default_nettype wire
